/* logic/exv_unit.sv */
// Behaviour
// - reset, undefined, trap vectors 0x0/0x4/0x8
// - aborts at 0xc/0x10; 0x14 unused
// - normal irq 0x18, fast irq 0x1c
// - fixed priority, reset highest, decode traps lowest
// - undefined and trap never coincide
// - data abort entry then fast irq at once
// - fast irq worst latency bounded by sum
// - least interrupt latency is four cycles
// - normal irq may wait behind fast irq
// - reset low: abandon, fetch incrementing words
// - reset release saves pc and status
// - reset release: supervisor, masks set, t clear
// - after reset fetch from zero, 32-bit state
// - not every unassigned encoding must trap
// - entry saves link, status, mode, fetches vector
// - fast irq masked by f, sampled per instruction
// - fast irq entry also masks normal irq
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module exv_unit (
    input wire logic pclk, // 25 mhz processor clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb write
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic active_low_reset_in, // core reset pin, active low
    input wire logic fiq_n, // fast interrupt pin, active low
    input wire logic irq_n, // normal interrupt pin, active low
    input wire logic data_abort, // memory aborted a data access
    input wire logic prefetch_abort, // executing instruction was fetch-aborted
    input wire logic undef_req, // decode: undefined instruction
    input wire logic swtrap_req, // decode: software_trap
    input wire logic instr_exec, // instruction really executes this cycle
    input wire logic instr_end, // last cycle of current instruction
    input wire logic [31:0] cur_pc, // address of executing instruction
    output logic [31:0] fetch_addr, // next fetch address
    output logic fetch_load, // pulse: pipeline refills from fetch_addr
    output logic abandon, // core held in reset, discard work
    output logic entry_busy, // exception entry in progress, stall
    output logic exc_taken, // pulse: an entry has completed
    output exv_pkg::exv_exc_type exc_kind, // kind of latest entry
    output logic [31:0] psw, // program_status_word
    output logic [31:0] link_reg_supervisor, // supervisor link register
    output logic [31:0] saved_status_supervisor // supervisor saved status
);
    typedef enum logic [1:0] {ST_RESET, ST_RUN, ST_ENTRY} exv_state_type;

    // pin synchronisers, two flops each; stage one is read only by stage two
    logic [2:0] sync1_q; // first stage: reset, fiq, irq
    logic [2:0] sync2_q; // second stage
    logic rst_in_s; // synchronised core reset, active low
    logic fiq_s; // synchronised fast irq request, active high
    logic irq_s; // synchronised normal irq request, active high

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
        end
        else
        begin
            sync1_q <= {active_low_reset_in, ~fiq_n, ~irq_n};
            sync2_q <= sync1_q;
        end
    end
    assign rst_in_s = sync2_q[2];
    assign fiq_s = sync2_q[1];
    assign irq_s = sync2_q[0];

    // sequencer state
    exv_state_type state_q, state_d; // core sequence
    logic [31:0] fetch_q, fetch_d; // fetch address
    logic load_q, load_d; // refill pulse
    logic taken_q, taken_d; // entry-complete pulse
    exv_pkg::exv_exc_type kind_q, kind_d; // exception being entered
    logic [1:0] cnt_q, cnt_d; // entry cycles left
    logic chain_q, chain_d; // data abort entry just completed
    logic dabt_q, dabt_d; // pending data abort
    logic [31:0] psw_q, psw_d; // program_status_word
    logic [31:0] link_q [5]; // banked link registers, one per mode
    logic [31:0] saved_q [5]; // banked saved status, one per mode
    logic [31:0] link_d [5];
    logic [31:0] saved_d [5];
    logic [2:0] bank_sel; // bank written on entry
    logic fiq_ok; // fast irq visible to the arbiter
    logic irq_ok; // normal irq visible to the arbiter
    logic window; // point where requests may be taken
    logic win_valid; // arbiter found a winner
    exv_pkg::exv_exc_type win_kind; // arbiter winner
    logic apb_wr; // write takes effect this edge
    logic pready_q, pready_d; // apb ready, one cycle after access starts
    logic pslverr_q, pslverr_d; // error for unmapped address
    logic [31:0] prdata_q, prdata_d; // captured read data

    // bank index of an exception's mode
    function automatic logic [2:0] bank_of(input exv_pkg::exv_exc_type k);
        unique case (k)
            exv_pkg::EXC_UNDEF: bank_of = 3'h1;
            exv_pkg::EXC_PABORT, exv_pkg::EXC_DABORT: bank_of = 3'h2;
            exv_pkg::EXC_IRQ: bank_of = 3'h3;
            exv_pkg::EXC_FIQ: bank_of = 3'h4;
            default: bank_of = 3'h0;
        endcase
    endfunction

    // return address saved in the link register
    function automatic logic [31:0] ret_addr(input exv_pkg::exv_exc_type k,
                                             input logic [31:0] base);
        if (k == exv_pkg::EXC_DABORT)
        begin
            ret_addr = base + exv_pkg::RET_OFS8;
        end
        else
        begin
            ret_addr = base + exv_pkg::RET_OFS4;
        end
    endfunction

    // masking and the sampling window
    assign fiq_ok = fiq_s & ~psw_q[exv_pkg::PSW_F_BIT];
    assign irq_ok = irq_s & ~psw_q[exv_pkg::PSW_I_BIT];
    // after a data abort entry the fast irq goes at once, no instruction between
    assign window = instr_end | (chain_q & fiq_ok);
    assign apb_wr = psel & penable & pwrite & pready_q & (paddr == exv_pkg::REG_PSW);

    // decode traps count only for an instruction that really executes;
    // unassigned encodings that decode does not flag simply run on
    exv_prio u_prio (
        .dabort(dabt_q),
        .fiq(fiq_ok),
        .irq(irq_ok),
        .pabort(prefetch_abort & instr_exec),
        .undef(undef_req & instr_exec),
        .swtrap(swtrap_req & instr_exec),
        .valid(win_valid),
        .kind(win_kind)
    );

    assign bank_sel = bank_of(win_kind);

    // next-state logic for the whole sequence
    always_comb
    begin
        state_d = state_q;
        fetch_d = fetch_q;
        load_d = 1'b0;
        taken_d = 1'b0;
        kind_d = kind_q;
        cnt_d = cnt_q;
        chain_d = chain_q;
        // a new abort beats the clear of the one being taken
        dabt_d = dabt_q | data_abort;
        psw_d = psw_q;
        link_d = link_q;
        saved_d = saved_q;
        if (apb_wr)
        begin
            // software steers masks and mode; hardware entry below overrides
            psw_d = (psw_q & ~exv_pkg::PSW_WR_MASK) | (pwdata & exv_pkg::PSW_WR_MASK);
        end
        if (!rst_in_s)
        begin
            // hold: drop work, walk fetch address word by word
            state_d = ST_RESET;
            fetch_d = fetch_q + exv_pkg::WORD_STEP;
            dabt_d = 1'b0;
            chain_d = 1'b0;
        end
        else
        begin
            unique case (state_q)
                ST_RESET:
                begin
                    // release: save pc/status, enter supervisor at zero
                    link_d[0] = cur_pc;
                    saved_d[0] = psw_q;
                    psw_d[exv_pkg::PSW_MODE_LSB +: exv_pkg::PSW_MODE_W] = exv_pkg::MODE_SVC;
                    psw_d[exv_pkg::PSW_I_BIT] = 1'b1;
                    psw_d[exv_pkg::PSW_F_BIT] = 1'b1;
                    psw_d[exv_pkg::PSW_T_BIT] = 1'b0;
                    fetch_d = exv_pkg::vector_of(exv_pkg::EXC_RESET);
                    load_d = 1'b1;
                    taken_d = 1'b1;
                    kind_d = exv_pkg::EXC_RESET;
                    state_d = ST_RUN;
                end
                ST_RUN:
                begin
                    chain_d = 1'b0;
                    if (window && win_valid)
                    begin
                        // save context now, refill once the entry time has run
                        kind_d = win_kind;
                        link_d[bank_sel] = ret_addr(win_kind,
                            chain_q ? exv_pkg::VEC_DABORT : cur_pc);
                        saved_d[bank_sel] = psw_q;
                        if (win_kind == exv_pkg::EXC_DABORT)
                        begin
                            dabt_d = data_abort;
                            cnt_d = 2'(exv_pkg::T_EXC - 1);
                        end
                        else
                        begin
                            cnt_d = 2'(exv_pkg::T_FIQ - 1);
                        end
                        state_d = ST_ENTRY;
                    end
                end
                ST_ENTRY:
                begin
                    if (cnt_q == 2'h1)
                    begin
                        // last entry cycle: new mode, masks, fetch from vector
                        psw_d[exv_pkg::PSW_MODE_LSB +: exv_pkg::PSW_MODE_W] =
                            exv_pkg::mode_of(kind_q);
                        psw_d[exv_pkg::PSW_I_BIT] = 1'b1;
                        psw_d[exv_pkg::PSW_T_BIT] = 1'b0;
                        if (kind_q == exv_pkg::EXC_FIQ)
                        begin
                            psw_d[exv_pkg::PSW_F_BIT] = 1'b1;
                        end
                        fetch_d = exv_pkg::vector_of(kind_q);
                        load_d = 1'b1;
                        taken_d = 1'b1;
                        chain_d = (kind_q == exv_pkg::EXC_DABORT);
                        state_d = ST_RUN;
                    end
                    cnt_d = cnt_q - 2'h1;
                end
                default:
                begin
                    state_d = ST_RESET;
                end
            endcase
        end
    end

    // sequence registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_RESET;
            fetch_q <= exv_pkg::VEC_RESET;
            load_q <= 1'b0;
            taken_q <= 1'b0;
            kind_q <= exv_pkg::EXC_RESET;
            cnt_q <= 2'h0;
            chain_q <= 1'b0;
            dabt_q <= 1'b0;
            psw_q <= exv_pkg::PSW_RESET;
            for (int i = 0; i < 5; i++)
            begin
                link_q[i] <= 32'h0000_0000;
                saved_q[i] <= 32'h0000_0000;
            end
        end
        else
        begin
            state_q <= state_d;
            fetch_q <= fetch_d;
            load_q <= load_d;
            taken_q <= taken_d;
            kind_q <= kind_d;
            cnt_q <= cnt_d;
            chain_q <= chain_d;
            dabt_q <= dabt_d;
            psw_q <= psw_d;
            link_q <= link_d;
            saved_q <= saved_d;
        end
    end

    // apb slave: one wait state, so ready and read data come from flops
    always_comb
    begin
        pready_d = psel & penable & ~pready_q;
        pslverr_d = 1'b0;
        prdata_d = 32'h0000_0000;
        if (pready_d)
        begin
            unique case (paddr)
                exv_pkg::REG_PSW: prdata_d = psw_q;
                exv_pkg::REG_LINK_SUP: prdata_d = link_q[0];
                exv_pkg::REG_SAVED_SUP: prdata_d = saved_q[0];
                exv_pkg::REG_CAUSE:
                begin
                    prdata_d[2:0] = kind_q;
                    prdata_d[exv_pkg::CAUSE_RESET_BIT] = (state_q == ST_RESET);
                end
                default: pslverr_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
        end
    end

    // outputs from flops; abandon and entry_busy are decoded from state_q
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign fetch_addr = fetch_q;
    assign fetch_load = load_q;
    assign abandon = (state_q == ST_RESET);
    assign entry_busy = (state_q == ST_ENTRY);
    assign exc_taken = taken_q;
    assign exc_kind = kind_q;
    assign psw = psw_q;
    assign link_reg_supervisor = link_q[0];
    assign saved_status_supervisor = saved_q[0];
endmodule
`default_nettype wire

/* logic/exv_pkg.sv */
package exv_pkg;
    // psw field positions
    localparam int PSW_MODE_LSB = 0;
    localparam int PSW_MODE_W = 5;
    localparam int PSW_T_BIT = 5;
    localparam int PSW_F_BIT = 6;
    localparam int PSW_I_BIT = 7;
    localparam logic [31:0] PSW_RESET = 32'h0000_00d3; // svc, i and f set, t clear
    localparam logic [31:0] PSW_WR_MASK = 32'h0000_00ff; // software-writable psw bits

    // mode codes; only supervisor is fixed, the rest are plain defaults
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_UND = 5'h1b;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_FIQ = 5'h11;

    // vector addresses
    localparam logic [31:0] VEC_RESET = 32'h0000_0000;
    localparam logic [31:0] VEC_UNDEF = 32'h0000_0004;
    localparam logic [31:0] VEC_SWTRAP = 32'h0000_0008;
    localparam logic [31:0] VEC_PABORT = 32'h0000_000c;
    localparam logic [31:0] VEC_DABORT = 32'h0000_0010;
    localparam logic [31:0] VEC_RSVD = 32'h0000_0014; // never used by any exception
    localparam logic [31:0] VEC_IRQ = 32'h0000_0018;
    localparam logic [31:0] VEC_FIQ = 32'h0000_001c;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [31:0] RET_OFS4 = 32'h0000_0004;
    localparam logic [31:0] RET_OFS8 = 32'h0000_0008;

    // latency figures in processor cycles
    localparam int T_SYNC_MAX = 3;
    localparam int T_SYNC_MIN = 2;
    localparam int T_LDM = 20;
    localparam int T_EXC = 3;
    localparam int T_FIQ = 2;
    localparam int T_FIQ_WORST = T_SYNC_MAX + T_LDM + T_EXC + T_FIQ;
    localparam int T_IRQ_MIN = T_SYNC_MIN + T_FIQ;

    // apb register byte offsets
    localparam logic [7:0] REG_PSW = 8'h00;
    localparam logic [7:0] REG_LINK_SUP = 8'h04;
    localparam logic [7:0] REG_SAVED_SUP = 8'h08;
    localparam logic [7:0] REG_CAUSE = 8'h0c;
    localparam int CAUSE_RESET_BIT = 8;

    typedef enum logic [2:0] {
        EXC_RESET, EXC_UNDEF, EXC_SWTRAP, EXC_PABORT, EXC_DABORT, EXC_IRQ, EXC_FIQ
    } exv_exc_type;

    // vector address of an exception
    function automatic logic [31:0] vector_of(input exv_exc_type k);
        unique case (k)
            EXC_RESET: vector_of = VEC_RESET;
            EXC_UNDEF: vector_of = VEC_UNDEF;
            EXC_SWTRAP: vector_of = VEC_SWTRAP;
            EXC_PABORT: vector_of = VEC_PABORT;
            EXC_DABORT: vector_of = VEC_DABORT;
            EXC_IRQ: vector_of = VEC_IRQ;
            default: vector_of = VEC_FIQ;
        endcase
    endfunction

    // mode entered by an exception
    function automatic logic [4:0] mode_of(input exv_exc_type k);
        unique case (k)
            EXC_UNDEF: mode_of = MODE_UND;
            EXC_PABORT, EXC_DABORT: mode_of = MODE_ABT;
            EXC_IRQ: mode_of = MODE_IRQ;
            EXC_FIQ: mode_of = MODE_FIQ;
            default: mode_of = MODE_SVC;
        endcase
    endfunction
endpackage

/* logic/exv_prio.sv */
`timescale 1ns/100ps
`default_nettype none
// fixed-priority pick among the requests sampled this cycle
module exv_prio (
    input wire logic dabort, // data abort pending
    input wire logic fiq, // fast interrupt, already masked
    input wire logic irq, // normal interrupt, already masked
    input wire logic pabort, // prefetch abort on executing instruction
    input wire logic undef, // undefined instruction on executing instruction
    input wire logic swtrap, // software trap on executing instruction
    output logic valid, // some exception wins
    output exv_pkg::exv_exc_type kind // the winner
);
    // reset is handled by the sequencer, not here
    always_comb
    begin
        valid = 1'b1;
        kind = exv_pkg::EXC_UNDEF;
        if (dabort)
        begin
            kind = exv_pkg::EXC_DABORT;
        end
        else if (fiq)
        begin
            kind = exv_pkg::EXC_FIQ;
        end
        else if (irq)
        begin
            kind = exv_pkg::EXC_IRQ;
        end
        else if (pabort)
        begin
            kind = exv_pkg::EXC_PABORT;
        end
        else if (swtrap)
        begin
            // decode never raises both, so their order is arbitrary
            kind = exv_pkg::EXC_SWTRAP;
        end
        else
        begin
            valid = undef;
        end
    end
endmodule
`default_nettype wire

/* tb/exv_unit_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module exv_unit_checker (
    input wire logic pclk, // processor clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic [7:0] paddr, // apb byte address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic [31:0] fetch_addr, // next fetch address
    input wire logic fetch_load, // refill pulse
    input wire logic abandon, // core reset held
    input wire logic entry_busy, // entry in progress
    input wire logic exc_taken, // entry completed
    input wire exv_pkg::exv_exc_type exc_kind, // kind of latest entry
    input wire logic [31:0] psw, // status word
    input wire logic [31:0] saved_status_supervisor // supervisor saved status
);
    logic [36:0] exp_vm; // expected vector and mode of exc_kind

    // hand-written, so a slip in the shared lookup shows
    always_comb
    begin
        case (exc_kind)
            exv_pkg::EXC_UNDEF: exp_vm = {32'h4, exv_pkg::MODE_UND};
            exv_pkg::EXC_SWTRAP: exp_vm = {32'h8, exv_pkg::MODE_SVC};
            exv_pkg::EXC_PABORT: exp_vm = {32'hc, exv_pkg::MODE_ABT};
            exv_pkg::EXC_DABORT: exp_vm = {32'h10, exv_pkg::MODE_ABT};
            exv_pkg::EXC_IRQ: exp_vm = {32'h18, exv_pkg::MODE_IRQ};
            exv_pkg::EXC_FIQ: exp_vm = {32'h1c, exv_pkg::MODE_FIQ};
            default: exp_vm = {32'h0, exv_pkg::MODE_SVC}; // reset entry
        endcase
    end

    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    vec_map_a: assert property (exc_taken |-> fetch_load && fetch_addr == exp_vm[36:5])
        else $error("entry fetched from the wrong vector");
    rsvd_vec_a: assert property (fetch_load |-> fetch_addr != 32'h14)
        else $error("reserved vector fetched");
    entry_mode_a: assert property (exc_taken |-> psw[4:0] == exp_vm[4:0] && psw[7] && !psw[5])
        else $error("entry mode or flags wrong");
    irq_gate_a: assert property (exc_taken && exc_kind == exv_pkg::EXC_IRQ |-> !$past(psw[7], 2))
        else $error("normal interrupt taken while masked");
    fiq_gate_a: assert property (exc_taken && exc_kind == exv_pkg::EXC_FIQ
        |-> !$past(psw[6], 2) && psw[6])
        else $error("fast interrupt gating wrong");
    walk_a: assert property (abandon ##1 abandon |-> fetch_addr == $past(fetch_addr) + 32'h4)
        else $error("fetch address not stepping in reset");
    release_a: assert property ($fell(abandon) |-> exc_taken && psw[7:0] == 8'hd3
        && fetch_addr == 32'h0 && exc_kind == exv_pkg::EXC_RESET)
        else $error("reset release entry wrong");
    save_a: assert property ($fell(abandon) |-> saved_status_supervisor == $past(psw))
        else $error("status not saved at reset release");
    busy_a: assert property ($rose(entry_busy) |-> ##[1:2] (exc_taken && !entry_busy))
        else $error("entry took too long");
    pulse_a: assert property (exc_taken |=> !exc_taken && !fetch_load)
        else $error("entry pulse too long");
    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb ready late");
    apb_err_a: assert property (psel && penable && pready |-> pslverr == (paddr > 8'h0c))
        else $error("apb error flag wrong");
endmodule

bind exv_unit exv_unit_checker exv_unit_checker_inst (.*);
`default_nettype wire

/* tb/exv_src_model.sv */
`timescale 1ns/100ps
`default_nettype none
// interrupt sources, abort signalling and core reset pin around the unit
module exv_src_model (
    input wire logic pclk, // processor clock
    input wire logic hold_reset, // keep the core reset pin low
    input wire logic want_fiq, // raise the fast interrupt
    input wire logic want_irq, // raise the normal interrupt
    input wire logic want_dabort, // one-cycle data abort strobe
    output var logic active_low_reset_in = 1'b0, // core reset pin
    output var logic fiq_n = 1'b1, // fast interrupt pin, active low
    output var logic irq_n = 1'b1, // normal interrupt pin, active low
    output var logic data_abort = 1'b0 // memory abort
);
    // pins follow one edge late; levels held until withdrawn
    always_ff @(posedge pclk)
    begin
        active_low_reset_in <= !hold_reset;
        fiq_n <= !want_fiq;
        irq_n <= !want_irq;
        data_abort <= want_dabort;
    end
endmodule
`default_nettype wire

/* tb/test_exception_vector_priority_unit.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) \
    begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("unexpected %s exp %h got %h", what, exp, got); end end
module test_exception_vector_priority_unit;
    logic pclk = 1'b0, presetn = 1'b0; // clock and reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // apb controls
    logic [7:0] paddr = 8'h00; // apb address
    logic [31:0] pwdata = 32'h0, cur_pc = 32'h0000_1234; // write data, executing pc
    logic hold_reset = 1'b1, want_fiq = 1'b0, want_irq = 1'b0, want_dabort = 1'b0; // sources
    logic prefetch_abort = 1'b0, undef_req = 1'b0, swtrap_req = 1'b0; // decode requests
    logic instr_exec = 1'b1, instr_end = 1'b0; // instruction progress
    logic active_low_reset_in, fiq_n, irq_n, data_abort; // model pins
    logic [31:0] prdata, fetch_addr, psw, link_reg_supervisor, saved_status_supervisor;
    logic pready, pslverr, fetch_load, abandon, entry_busy, exc_taken; // unit flags
    exv_pkg::exv_exc_type exc_kind; // kind of latest entry
    int bad_count = 0, tests_run = 0, n; // mismatches, comparisons, edges waited
    logic [31:0] rd; // last apb read data
    logic err; // last apb error

    exv_unit exv_unit_inst (.*);
    exv_src_model exv_src_model_inst (.*);

    initial forever #20 pclk = ~pclk;

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // whole run is well under a thousand cycles
    initial
    begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        stop_test();
    end

    // one apb transfer, started right after an edge; an idle edge follows
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // vector of each kind, kept independent of the unit's lookup
    function automatic logic [31:0] vec(input exv_pkg::exv_exc_type k);
        case (k)
            exv_pkg::EXC_UNDEF: vec = 32'h4;
            exv_pkg::EXC_SWTRAP: vec = 32'h8;
            exv_pkg::EXC_PABORT: vec = 32'hc;
            exv_pkg::EXC_DABORT: vec = 32'h10;
            exv_pkg::EXC_IRQ: vec = 32'h18;
            exv_pkg::EXC_FIQ: vec = 32'h1c;
            default: vec = 32'h0;
        endcase
    endfunction

    // edges until the entry pulse is sampled
    task automatic wait_taken;
        n = 0;
        do @(posedge pclk) n++; while (exc_taken !== 1'b1 && n < 40);
        if (n >= 40) `CHK("entry completion", 1'b1, 1'b0)
    endtask

    // optional one-cycle end of instruction, then judge the entry
    task automatic step(input exv_pkg::exv_exc_type k, input logic [7:0] pexp,
                        input logic pulse);
        if (pulse)
        begin
            instr_end <= 1'b1;
            @(posedge pclk);
            instr_end <= 1'b0;
        end
        wait_taken();
        `CHK("kind", k, exc_kind)
        `CHK("vector", vec(k), fetch_addr)
        `CHK("psw", pexp, psw[7:0])
    endtask

    task automatic t_core_reset;
        logic [31:0] a0;
        apb(1'b1, exv_pkg::REG_PSW, 32'h11f);
        apb(1'b0, exv_pkg::REG_PSW, 32'h0);
        `CHK("psw readback", 32'h1f, rd)
        apb(1'b0, exv_pkg::REG_CAUSE, 32'h0);
        `CHK("cause in reset", 1'b1, rd[8])
        apb(1'b0, 8'h10, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        a0 = fetch_addr;
        @(posedge pclk);
        `CHK("reset fetch walk", a0 + 32'h4, fetch_addr)
        `CHK("abandon", 1'b1, abandon)
        hold_reset <= 1'b0;
        step(exv_pkg::EXC_RESET, 8'hd3, 1'b0);
        `CHK("saved status", 32'h1f, saved_status_supervisor)
        `CHK("link", cur_pc, link_reg_supervisor)
        `CHK("released", 1'b0, abandon)
        $display("core reset test done");
    endtask

    // all but undef pending at once, peeled off by priority; irq stays masked by i until after the trap, undef last
    task automatic t_chain;
        apb(1'b1, exv_pkg::REG_PSW, 32'h30);
        swtrap_req <= 1'b1;
        prefetch_abort <= 1'b1;
        want_irq <= 1'b1;
        want_fiq <= 1'b1;
        want_dabort <= 1'b1;
        @(posedge pclk);
        want_dabort <= 1'b0;
        repeat (4) @(posedge pclk);
        step(exv_pkg::EXC_DABORT, 8'h97, 1'b1);
        step(exv_pkg::EXC_FIQ, 8'hd1, 1'b0);
        `CHK("chain gap", exv_pkg::T_FIQ, n)
        want_fiq <= 1'b0;
        step(exv_pkg::EXC_PABORT, 8'hd7, 1'b1);
        prefetch_abort <= 1'b0;
        step(exv_pkg::EXC_SWTRAP, 8'hd3, 1'b1);
        `CHK("trap link", cur_pc + 32'h4, link_reg_supervisor)
        `CHK("trap saved", 32'hd7, saved_status_supervisor)
        swtrap_req <= 1'b0;
        undef_req <= 1'b1;
        apb(1'b1, exv_pkg::REG_PSW, 32'h10);
        step(exv_pkg::EXC_IRQ, 8'h92, 1'b1);
        want_irq <= 1'b0;
        step(exv_pkg::EXC_UNDEF, 8'h9b, 1'b1);
        undef_req <= 1'b0;
        $display("priority chain test done");
    endtask

    // masked interrupts and requests of a non-executed instruction stay silent
    task automatic t_gated;
        int hits;
        apb(1'b1, exv_pkg::REG_PSW, 32'hd0);
        want_fiq <= 1'b1;
        want_irq <= 1'b1;
        undef_req <= 1'b1;
        prefetch_abort <= 1'b1;
        instr_exec <= 1'b0;
        instr_end <= 1'b1;
        hits = 0;
        repeat (12) @(posedge pclk) if (exc_taken === 1'b1) hits++;
        `CHK("silent entries", 0, hits)
        instr_end <= 1'b0;
        instr_exec <= 1'b1;
        undef_req <= 1'b0;
        prefetch_abort <= 1'b0;
        want_fiq <= 1'b0;
        want_irq <= 1'b0;
        repeat (4) @(posedge pclk);
        $display("gating test done");
    endtask

    // shortest path from pin to entry for both interrupt kinds
    task automatic t_latency;
        apb(1'b1, exv_pkg::REG_PSW, 32'h10);
        instr_end <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            if (i == 0)
                want_irq <= 1'b1;
            else
                want_fiq <= 1'b1;
            do @(posedge pclk); while ((i == 0 ? irq_n : fiq_n) !== 1'b0);
            wait_taken();
            `CHK("interrupt latency", exv_pkg::T_IRQ_MIN, n)
            `CHK("interrupt kind", i == 0 ? exv_pkg::EXC_IRQ : exv_pkg::EXC_FIQ, exc_kind)
            want_irq <= 1'b0;
        end
        want_fiq <= 1'b0;
        instr_end <= 1'b0;
        $display("latency test done");
    endtask

    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_core_reset();
        t_chain();
        t_gated();
        t_latency();
        stop_test();
    end
endmodule
`default_nettype wire
